/* File: common/acc_pkg.sv */
package acc_pkg;

	// register byte addresses
	localparam logic [7:0] ACC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] ACC_STAT_ADDR = 8'h04;
	localparam logic [7:0] ACC_FIRST_START_ADDR = 8'h08;
	localparam logic [7:0] ACC_SECOND_START_ADDR = 8'h0C;
	localparam logic [7:0] ACC_SIZE_ADDR = 8'h10;

	// control register bit positions
	localparam int ACC_SW_RESET_BIT = 31;
	localparam int ACC_DIAG_BIT = 30;
	localparam int ACC_EXEMPT_BIT = 29;
	localparam int ACC_CAPTURE_BIT = 0;
	localparam int ACC_FIRST_IEN_BIT = 1;
	localparam int ACC_SECOND_IEN_BIT = 2;
	localparam int ACC_BWERR_IEN_BIT = 3;
	localparam int ACC_LOST_IEN_BIT = 4;
	localparam int ACC_FIRST_CLR_BIT = 5;
	localparam int ACC_SECOND_CLR_BIT = 6;
	localparam int ACC_BWERR_CLR_BIT = 7;
	localparam int ACC_LOST_CLR_BIT = 8;

	// status register bit positions
	localparam int ACC_CURRENT_BIT = 0;
	localparam int ACC_FIRST_FULL_BIT = 1;
	localparam int ACC_SECOND_FULL_BIT = 2;
	localparam int ACC_BWERR_BIT = 3;
	localparam int ACC_LOST_BIT = 4;

	// exact value that triggers the software reset
	localparam logic [31:0] ACC_SW_RESET_VALUE = 32'h80000000;
	// buffers are 64-byte aligned, sizes a multiple of 64 samples
	localparam logic [31:0] ACC_ALIGN_MASK = 32'hFFFFFFC0;
	localparam logic [31:0] ACC_BASE_RESET = 32'h00000000;
	localparam logic [31:0] ACC_SIZE_RESET = 32'h00000000;

	typedef struct packed {
		logic diagnostic_select;
		logic power_down_exempt;
		logic capture_on;
		logic first_full_irq_en;
		logic second_full_irq_en;
		logic bandwidth_err_irq_en;
		logic lost_sample_irq_en;
	} acc_ctrl_t;

	localparam acc_ctrl_t ACC_CTRL_RESET = '{default: 1'b0};

	typedef struct packed {
		logic first_buffer_current;
		logic first_buffer_filled;
		logic second_buffer_filled;
		logic bandwidth_error_flag;
		logic lost_sample_flag;
	} acc_stat_t;

	localparam acc_stat_t ACC_STAT_RESET = '{first_buffer_current: 1'b1, default: 1'b0};

	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_FILL_FIRST = 3'b010,
		ACC_FILL_SECOND = 3'b100
	} acc_state_t;

endpackage : acc_pkg

/* File: rtl/acc_capture_ctrl.sv */
`timescale 1ns/100ps
// Behaviour
// - writing 0x80000000 resets whole capture unit
// - software reset bit always reads zero
// - diagnostic select defaults zero, one selects diagnostic
// - exemption zero joins power down, one stays
// - capture on enables sample DMA writing
// - first full enable raises shared request
// - second full enable raises shared request
// - bandwidth error enable raises shared request
// - lost sample enable raises shared request
// - first clear strobe clears first full flag
// - second clear strobe clears second full flag
// - bandwidth clear strobe clears bandwidth flag
// - lost clear strobe clears lost flag
// - current buffer bit one means first buffer
// - first full flag set when first fills
// - first clear makes first buffer fresh
// - status fields read only to software
// - second full flag, clear makes fresh
// - bandwidth error on sample while staging busy
// - lost sample when the current buffer is still full
// - full buffer switches capture to other gaplessly
module acc_capture_ctrl
	import acc_pkg::*;
#(
	parameter int SIZE_W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// capture datapath events
	input wire logic sample_in,
	input wire logic staging_busy,
	input wire logic global_power_down,
	// unit outputs
	output logic sample_take,
	output logic sample_to_first,
	output logic [31:0] sample_addr,
	output logic unit_active,
	output logic diag_mode,
	output logic capture_irq
);

	acc_ctrl_t ctrl_q, ctrl_d;
	acc_stat_t stat_q, stat_d;
	acc_state_t state_q, state_d;
	logic [31:0] first_start_q, first_start_d, second_start_q, second_start_d;
	logic [SIZE_W-1:0] size_q, size_d, count_q, count_d;
	logic first_ready_q, first_ready_d, second_ready_q, second_ready_d;
	logic [31:0] rdata_q, rdata_d;
	logic take_q, take_d, to_first_q, to_first_d, active_q, active_d, irq_q, irq_d;
	logic [31:0] addr_q, addr_d;

	logic ctrl_wr, sw_reset, clr_first, clr_second, clr_bw, clr_lost;
	logic running, last_sample;

	assign ctrl_wr = reg_write && (reg_addr == ACC_CTRL_ADDR);
	assign sw_reset = ctrl_wr && (reg_wdata == ACC_SW_RESET_VALUE);
	assign clr_first = ctrl_wr && !sw_reset && reg_wdata[ACC_FIRST_CLR_BIT];
	assign clr_second = ctrl_wr && !sw_reset && reg_wdata[ACC_SECOND_CLR_BIT];
	assign clr_bw = ctrl_wr && !sw_reset && reg_wdata[ACC_BWERR_CLR_BIT];
	assign clr_lost = ctrl_wr && !sw_reset && reg_wdata[ACC_LOST_CLR_BIT];

	assign running = ctrl_q.capture_on && (!global_power_down || ctrl_q.power_down_exempt);
	assign last_sample = (count_q + SIZE_W'(1)) >= size_q;

	// control and buffer registers
	always_comb begin
		ctrl_d = ctrl_q;
		first_start_d = first_start_q;
		second_start_d = second_start_q;
		size_d = size_q;
		if (sw_reset) begin
			ctrl_d = ACC_CTRL_RESET;
			first_start_d = ACC_BASE_RESET;
			second_start_d = ACC_BASE_RESET;
			size_d = SIZE_W'(ACC_SIZE_RESET);
		end else if (ctrl_wr) begin
			ctrl_d.diagnostic_select = reg_wdata[ACC_DIAG_BIT];
			ctrl_d.power_down_exempt = reg_wdata[ACC_EXEMPT_BIT];
			ctrl_d.capture_on = reg_wdata[ACC_CAPTURE_BIT];
			ctrl_d.first_full_irq_en = reg_wdata[ACC_FIRST_IEN_BIT];
			ctrl_d.second_full_irq_en = reg_wdata[ACC_SECOND_IEN_BIT];
			ctrl_d.bandwidth_err_irq_en = reg_wdata[ACC_BWERR_IEN_BIT];
			ctrl_d.lost_sample_irq_en = reg_wdata[ACC_LOST_IEN_BIT];
		end else if (reg_write && reg_addr == ACC_FIRST_START_ADDR) begin
			first_start_d = reg_wdata & ACC_ALIGN_MASK;
		end else if (reg_write && reg_addr == ACC_SECOND_START_ADDR) begin
			second_start_d = reg_wdata & ACC_ALIGN_MASK;
		end else if (reg_write && reg_addr == ACC_SIZE_ADDR) begin
			size_d = SIZE_W'(reg_wdata & ACC_ALIGN_MASK);
		end
	end

	// status has no software write path
	// capture sequencing and status flags
	always_comb begin
		stat_d = stat_q;
		state_d = state_q;
		count_d = count_q;
		first_ready_d = first_ready_q;
		second_ready_d = second_ready_q;
		take_d = 1'b0;
		to_first_d = to_first_q;
		addr_d = addr_q;
		case (state_q)
			ACC_IDLE: begin
				if (running) begin
					state_d = stat_q.first_buffer_current ? ACC_FILL_FIRST : ACC_FILL_SECOND;
				end
			end
			ACC_FILL_FIRST, ACC_FILL_SECOND: begin
				if (!running) begin
					state_d = ACC_IDLE;
				end else if (sample_in) begin
					// sample arrives while staging not drained
					if (staging_busy) begin
						stat_d.bandwidth_error_flag = 1'b1;
					end
					if (state_q == ACC_FILL_FIRST ? !first_ready_q : !second_ready_q) begin
						stat_d.lost_sample_flag = 1'b1;
					end else begin
						take_d = 1'b1;
						to_first_d = (state_q == ACC_FILL_FIRST);
						addr_d = (state_q == ACC_FILL_FIRST ? first_start_q : second_start_q) + 32'(count_q);
						count_d = count_q + SIZE_W'(1);
						if (last_sample) begin
							count_d = '0;
							if (state_q == ACC_FILL_FIRST) begin
								stat_d.first_buffer_filled = 1'b1;
								first_ready_d = 1'b0;
								stat_d.first_buffer_current = 1'b0;
								state_d = ACC_FILL_SECOND;
							end else begin
								stat_d.second_buffer_filled = 1'b1;
								second_ready_d = 1'b0;
								stat_d.first_buffer_current = 1'b1;
								state_d = ACC_FILL_FIRST;
							end
						end
					end
				end
			end
			default: begin
				state_d = ACC_IDLE;
			end
		endcase
		// clears act only where no set fires in this cycle: the set wins
		// first clear
		// acknowledged first buffer is fresh; a fill in the same cycle keeps it full
		if (clr_first && !(stat_d.first_buffer_filled && !stat_q.first_buffer_filled)) begin
			stat_d.first_buffer_filled = 1'b0;
			first_ready_d = 1'b1;
		end
		if (clr_second && !(stat_d.second_buffer_filled && !stat_q.second_buffer_filled)) begin
			stat_d.second_buffer_filled = 1'b0;
			second_ready_d = 1'b1;
		end
		if (clr_bw && stat_q.bandwidth_error_flag && stat_d.bandwidth_error_flag
				&& !(sample_in && staging_busy && state_q != ACC_IDLE && running)) begin
			stat_d.bandwidth_error_flag = 1'b0;
		end
		// lost clear or software reset, the only ways out
		if (clr_lost && stat_q.lost_sample_flag && !(stat_d.lost_sample_flag && take_d == 1'b0
				&& sample_in && state_q != ACC_IDLE && running)) begin
			stat_d.lost_sample_flag = 1'b0;
		end
		if (sw_reset) begin
			stat_d = ACC_STAT_RESET;
			state_d = ACC_IDLE;
			count_d = '0;
			first_ready_d = 1'b1;
			second_ready_d = 1'b1;
			take_d = 1'b0;
			to_first_d = 1'b1;
			addr_d = '0;
		end
	end

	// outputs and read data
	always_comb begin
		rdata_d = '0;
		if (reg_read) begin
			case (reg_addr)
				ACC_CTRL_ADDR: begin
					// reset and clear bits read zero
					rdata_d[ACC_DIAG_BIT] = ctrl_q.diagnostic_select;
					rdata_d[ACC_EXEMPT_BIT] = ctrl_q.power_down_exempt;
					rdata_d[ACC_CAPTURE_BIT] = ctrl_q.capture_on;
					rdata_d[ACC_FIRST_IEN_BIT] = ctrl_q.first_full_irq_en;
					rdata_d[ACC_SECOND_IEN_BIT] = ctrl_q.second_full_irq_en;
					rdata_d[ACC_BWERR_IEN_BIT] = ctrl_q.bandwidth_err_irq_en;
					rdata_d[ACC_LOST_IEN_BIT] = ctrl_q.lost_sample_irq_en;
				end
				ACC_STAT_ADDR: begin
					rdata_d[ACC_CURRENT_BIT] = stat_q.first_buffer_current;
					rdata_d[ACC_FIRST_FULL_BIT] = stat_q.first_buffer_filled;
					rdata_d[ACC_SECOND_FULL_BIT] = stat_q.second_buffer_filled;
					rdata_d[ACC_BWERR_BIT] = stat_q.bandwidth_error_flag;
					rdata_d[ACC_LOST_BIT] = stat_q.lost_sample_flag;
				end
				ACC_FIRST_START_ADDR: rdata_d = first_start_q;
				ACC_SECOND_START_ADDR: rdata_d = second_start_q;
				ACC_SIZE_ADDR: rdata_d = 32'(size_q);
				default: rdata_d = '0;
			endcase
		end
		active_d = running;
		// each cause gated by its enable
		irq_d = (stat_d.first_buffer_filled && ctrl_d.first_full_irq_en)
			|| (stat_d.second_buffer_filled && ctrl_d.second_full_irq_en)
			|| (stat_d.bandwidth_error_flag && ctrl_d.bandwidth_err_irq_en)
			|| (stat_d.lost_sample_flag && ctrl_d.lost_sample_irq_en);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q <= ACC_CTRL_RESET;
			stat_q <= ACC_STAT_RESET;
			state_q <= ACC_IDLE;
			first_start_q <= ACC_BASE_RESET;
			second_start_q <= ACC_BASE_RESET;
			size_q <= '0;
			count_q <= '0;
			first_ready_q <= 1'b1;
			second_ready_q <= 1'b1;
			rdata_q <= '0;
			take_q <= 1'b0;
			to_first_q <= 1'b1;
			addr_q <= '0;
			active_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			state_q <= state_d;
			first_start_q <= first_start_d;
			second_start_q <= second_start_d;
			size_q <= size_d;
			count_q <= count_d;
			first_ready_q <= first_ready_d;
			second_ready_q <= second_ready_d;
			rdata_q <= rdata_d;
			take_q <= take_d;
			to_first_q <= to_first_d;
			addr_q <= addr_d;
			active_q <= active_d;
			irq_q <= irq_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign sample_take = take_q;
	assign sample_to_first = to_first_q;
	assign sample_addr = addr_q;
	assign unit_active = active_q;
	assign diag_mode = ctrl_q.diagnostic_select;
	assign capture_irq = irq_q;

	a_sw_reset_clears: assert property (@(posedge clock) disable iff (reset)
		sw_reset |=> (ctrl_q == ACC_CTRL_RESET) && stat_q.first_buffer_current && !capture_irq)
		else $error("software reset did not restore defaults");
	a_reset_bit_zero: assert property (@(posedge clock) disable iff (reset)
		$past(reg_read) && $past(reg_addr) == ACC_CTRL_ADDR |-> reg_rdata[ACC_SW_RESET_BIT] == 1'b0 && reg_rdata[8:5] == 4'h0)
		else $error("reset or clear bit read back nonzero");
	a_diag_follows: assert property (@(posedge clock) disable iff (reset)
		ctrl_wr && !sw_reset |=> diag_mode == $past(reg_wdata[ACC_DIAG_BIT]))
		else $error("diagnostic select not stored");
	a_no_take_off: assert property (@(posedge clock) disable iff (reset)
		!ctrl_q.capture_on |=> !sample_take)
		else $error("sample taken while capture off");
	a_first_clear: assert property (@(posedge clock) disable iff (reset)
		clr_first && !sample_in |=> !stat_q.first_buffer_filled)
		else $error("first full flag not cleared");
	a_lost_sticky: assert property (@(posedge clock) disable iff (reset)
		stat_q.lost_sample_flag && !clr_lost && !sw_reset |=> stat_q.lost_sample_flag)
		else $error("lost sample flag dropped without its clear");
	a_status_ro: assert property (@(posedge clock) disable iff (reset)
		reg_write && reg_addr == ACC_STAT_ADDR && !sample_in |=> $stable(stat_q))
		else $error("status changed by a software write");
	a_irq_level: assert property (@(posedge clock) disable iff (reset)
		capture_irq == ((stat_q.first_buffer_filled && ctrl_q.first_full_irq_en)
		|| (stat_q.second_buffer_filled && ctrl_q.second_full_irq_en)
		|| (stat_q.bandwidth_error_flag && ctrl_q.bandwidth_err_irq_en)
		|| (stat_q.lost_sample_flag && ctrl_q.lost_sample_irq_en)))
		else $error("interrupt request does not match enabled flags");

endmodule // acc_capture_ctrl

/* File: verif/acc_capture_ctrl_tb_top.sv */
`timescale 1ns/100ps
module acc_capture_ctrl_tb_top;
	import acc_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic global_power_down = 1'b0;
	logic fire = 1'b0;
	logic slow = 1'b0;
	logic [31:0] reg_rdata, sample_addr, v, b1, b2, sz;
	logic sample_in, staging_busy, sample_take, sample_to_first, unit_active, diag_mode, capture_irq;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	bit cur = 1'b1;
	bit f1, f2, bw, lost;
	bit [3:0] en;

	always #50 clock = ~clock;

	acc_capture_ctrl i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_in(sample_in),
		.staging_busy(staging_busy), .global_power_down(global_power_down), .sample_take(sample_take),
		.sample_to_first(sample_to_first), .sample_addr(sample_addr), .unit_active(unit_active),
		.diag_mode(diag_mode), .capture_irq(capture_irq));

	acc_sample_src i_src (.clock(clock), .reset(reset), .fire(fire), .slow(slow),
		.sample_take(sample_take), .sample_in(sample_in), .staging_busy(staging_busy));

	task automatic end_of_test();
		if (fails == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// software control write, mirrored in the model; undefined bits always written as zero
	task automatic ctl(input logic [31:0] d);
		wr(ACC_CTRL_ADDR, d);
		if (d === ACC_SW_RESET_VALUE) begin
			{cur, f1, f2, bw, lost, en} = {1'b1, 8'h00};
			b1 = ACC_BASE_RESET;
			b2 = ACC_BASE_RESET;
		end else begin
			en = d[4:1];
			f1 = f1 & ~d[5];
			f2 = f2 & ~d[6];
			bw = bw & ~d[7];
			lost = lost & ~d[8];
		end
	endtask

	task automatic st();
		rd(ACC_STAT_ADDR, v);
		chk(v, {27'h0, lost, bw, f2, f1, cur});
		chk(capture_irq, |({lost, bw, f2, f1} & en));
	endtask

	// one sample; size zero makes every buffer full after one sample
	task automatic smp();
		@(posedge clock) fire <= 1'b1;
		@(posedge clock) fire <= 1'b0;
		@(posedge clock) #1;
		if (cur ? f1 : f2) begin
			lost = 1'b1;
			chk(sample_take, 1'b0);
		end else begin
			chk(sample_take, 1'b1);
			chk(sample_to_first, cur);
			chk(sample_addr, cur ? b1 : b2);
			if (cur) f1 = 1'b1;
			else f2 = 1'b1;
			cur = ~cur;
		end
	endtask

	initial begin
		void'($urandom(99670));
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		rd(ACC_CTRL_ADDR, v);
		chk(v, 32'h0);
		st();
		rd(ACC_FIRST_START_ADDR, v);
		chk(v, ACC_BASE_RESET);
		rd(8'h20, v);
		chk(v, 32'h0);
		v = $urandom();
		wr(ACC_FIRST_START_ADDR, v);
		b1 = v & ACC_ALIGN_MASK;
		v = $urandom();
		wr(ACC_SECOND_START_ADDR, v);
		b2 = v & ACC_ALIGN_MASK;
		v = $urandom();
		wr(ACC_SIZE_ADDR, v);
		sz = v & ACC_ALIGN_MASK;
		rd(ACC_FIRST_START_ADDR, v);
		chk(v, b1);
		rd(ACC_SECOND_START_ADDR, v);
		chk(v, b2);
		rd(ACC_SIZE_ADDR, v);
		chk(v, sz);
		// back to size zero so that every sample below fills its buffer
		wr(ACC_SIZE_ADDR, 32'h0);
		@(posedge clock) global_power_down <= 1'b1;
		ctl(32'hE00001FF);
		rd(ACC_CTRL_ADDR, v);
		chk(v, 32'h6000001F);
		chk(diag_mode, 1'b1);
		chk(unit_active, 1'b1);
		ctl(32'h0000001F);
		repeat (2) @(posedge clock);
		#1 chk(unit_active, 1'b0);
		@(posedge clock) global_power_down <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk(unit_active, 1'b1);
		chk(diag_mode, 1'b0);
		wr(ACC_STAT_ADDR, 32'h0);
		st();
		repeat (3) begin
			smp();
			st();
		end
		for (int i = 0; i < 4; i++) begin
			ctl(32'h1F | (32'h20 << i));
			st();
		end
		smp();
		ctl(32'h01);
		st();
		ctl(32'h03);
		st();
		ctl(ACC_SW_RESET_VALUE);
		rd(ACC_CTRL_ADDR, v);
		chk(v, 32'h0);
		st();
		ctl(32'h09);
		slow <= 1'b1;
		smp();
		@(posedge clock) fire <= 1'b1;
		@(posedge clock) fire <= 1'b0;
		// the second sample goes to the other buffer while staging is still busy
		{f2, cur, bw} = 3'h7;
		repeat (3) @(posedge clock);
		rd(ACC_STAT_ADDR, v);
		chk(v[3], 1'b1);
		chk(capture_irq, 1'b1);
		ctl(32'h89);
		rd(ACC_STAT_ADDR, v);
		chk(v[3], 1'b0);
		st();
		end_of_test();
	end
endmodule // acc_capture_ctrl_tb_top

/* File: verif/acc_sample_src.sv */
`timescale 1ns/100ps
module acc_sample_src (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// bench control
	input wire logic fire,
	input wire logic slow,
	input wire logic sample_take,
	// toward the unit
	output logic sample_in,
	output logic staging_busy
);
	logic [2:0] drain_q;
	logic [2:0] drain_d;
	logic pulse_q;
	// a slow highway keeps the staging buffer busy for six cycles per sample
	always_comb begin
		drain_d = drain_q;
		if (sample_take && slow) begin
			drain_d = 3'h6;
		end else if (drain_q != 3'h0) begin
			drain_d = drain_q - 3'h1;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			drain_q <= 3'h0;
			pulse_q <= 1'b0;
		end else begin
			drain_q <= drain_d;
			pulse_q <= fire;
		end
	end
	assign sample_in = pulse_q;
	assign staging_busy = drain_q != 3'h0;
endmodule // acc_sample_src
